//--- core/stat_pkg.sv
// Constants for the serial flash status register block.
// Assumes one core clock domain; the serial pins are asynchronous to it.
package stat_pkg;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_WRITE_STATUS2 = 8'h31;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_OTP_PROGRAM = 8'h9b;
  localparam logic [7:0] OP_ERASE_PAGE = 8'h81;
  localparam logic [7:0] OP_ERASE_SMALL = 8'h20;
  localparam logic [7:0] OP_ERASE_LARGE = 8'h52;
  localparam logic [7:0] OP_CHIP_ERASE = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_ALT = 8'hc7;
  localparam logic [7:0] OP_SOFT_RESET = 8'hf0;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int LOCK_BIT = 7;
  localparam int FAIL_BIT = 5;
  localparam int PIN_BIT = 4;
  localparam int PROT_BIT = 2;
  localparam int LATCH_BIT = 1;
  localparam int BUSY_BIT = 0;
  localparam int ALLOW_BIT = 4;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic LOCK_RST = 1'b0;
  localparam logic PROT_RST = 1'b0;
  localparam logic LATCH_RST = 1'b0;
  localparam logic FAIL_RST = 1'b0;
  localparam logic ALLOW_RST = 1'b0;

  // ****************************************************************
  // Frame byte counts
  // ****************************************************************
  localparam logic [1:0] BYTES_OPCODE = 2'h1;
  localparam logic [1:0] BYTES_ONE_DATA = 2'h2;

endpackage : stat_pkg

//--- core/spi_frame_if.sv
// Serial frame events passed from the pin sampler to the command logic.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps
interface spi_frame_if;
  logic frame_on;
  logic sck_rise;
  logic sck_fall;
  logic byte_done;
  logic [7:0] byte_val;
  logic [1:0] byte_cnt;
  logic aligned;
  logic frame_end;

  modport shifter (output frame_on, sck_rise, sck_fall, byte_done,
    byte_val, byte_cnt, aligned, frame_end);
  modport core (input frame_on, sck_rise, sck_fall, byte_done,
    byte_val, byte_cnt, aligned, frame_end);
endinterface : spi_frame_if

//--- core/spi_shifter.sv
// Samples the serial pins on the core clock and turns them into events.
// Assumes the serial clock runs well below a quarter of the core clock.
`timescale 1ns/10ps
module spi_shifter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Serial pins
  input wire logic sck_pin,
  input wire logic cs_n_pin,
  input wire logic mosi_pin,
  // Frame events
  spi_frame_if.shifter link
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic sck_d;
  logic cs_d;
  logic [2:0] bit_cnt;
  logic [6:0] shift;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= 3'h7;
      pin_s2 <= 3'h7;
      sck_d <= 1'b1;
      cs_d <= 1'b1;
    end else begin
      pin_s1 <= {mosi_pin, cs_n_pin, sck_pin};
      pin_s2 <= pin_s1;
      sck_d <= pin_s2[0];
      cs_d <= pin_s2[1];
    end
  end

  // ****************************************************************
  // Edge events
  // ****************************************************************
  assign link.frame_on = !pin_s2[1];
  assign link.sck_rise = link.frame_on && pin_s2[0] && !sck_d;
  assign link.sck_fall = link.frame_on && !pin_s2[0] && sck_d;
  assign link.frame_end = pin_s2[1] && !cs_d;
  assign link.aligned = (bit_cnt == 3'h0);

  // ****************************************************************
  // Bit and byte counting
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= 3'h0;
      shift <= 7'h00;
      link.byte_done <= 1'b0;
      link.byte_val <= 8'h00;
      link.byte_cnt <= 2'h0;
    end else begin
      link.byte_done <= link.sck_rise && (bit_cnt == 3'h7);
      if (!link.frame_on) begin
        bit_cnt <= 3'h0;
        link.byte_cnt <= 2'h0;
      end else if (link.sck_rise) begin
        bit_cnt <= bit_cnt + 3'h1;
        shift <= {shift[5:0], pin_s2[2]};
        if (bit_cnt == 3'h7) begin
          link.byte_val <= {shift, pin_s2[2]};
        end
      end
      if (link.frame_on && link.byte_done && link.byte_cnt != 2'h3) begin
        link.byte_cnt <= link.byte_cnt + 2'h1;
      end
    end
  end

endmodule : spi_shifter

//--- core/flash_status.sv
// Status register logic of a serial flash, read and written over SPI.
// Assumes a program/erase engine on the core clock reports busy and end.
//
// Summary of operation
// - Opcode 05h, then status bits each clock.
// - Status read answered even while busy.
// - Byte one then byte two, MSB first, repeating.
// - Each repetition carries freshly sampled values.
// - Chip select release ends read, output off.
// - Only lock, protect and soft reset allow bits are writable.
// - Lock plus asserted pin freezes protect bit.
// - Lock clear allows protect change; resets zero.
// - Pin asserted: lock may only be set.
// - Failure flag updated after every non-aborted operation.
// - Aborted operations never set failure flag.
// - Pin state bit is inverse of pin assertion.
// - Protect bit blocks array program and erase, not OTP.
// - Latch clear rejects program, erase, status write.
// - Latch cleared by reset and soft reset.
// - Latch cleared after listed commands end.
// - Of opcodes, only full write-class ones clear latch.
// - Busy bit high during internal operations.
// - Busy shown at bit zero of both bytes.
// - Soft reset allow bit resets to zero.
// - Status write byte: bit 7 lock, 2 protect.
`timescale 1ns/10ps
module flash_status (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Serial pins
  input wire logic sck_pin,
  input wire logic cs_n_pin,
  input wire logic mosi_pin,
  output logic miso_out,
  output logic miso_oe,
  // Write protect pin, asserted low
  input wire logic protect_n_pin,
  // Program and erase engine
  input wire logic op_busy,
  input wire logic op_end,
  input wire logic op_error,
  input wire logic op_aborted,
  input wire logic hold_abort,
  output logic op_start,
  output logic [7:0] op_code,
  output logic soft_reset
);

  // ****************************************************************
  // Frame sampler
  // ****************************************************************
  spi_frame_if link ();

  spi_shifter u_shifter (
    .core_clk(core_clk),
    .rst(rst),
    .sck_pin(sck_pin),
    .cs_n_pin(cs_n_pin),
    .mosi_pin(mosi_pin),
    .link(link.shifter)
  );

  // ****************************************************************
  // State and registers
  // ****************************************************************
  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_cmd = 4'b0010,
    st_read = 4'b0100,
    st_arg = 4'b1000
  } frame_state_e;

  frame_state_e state;
  frame_state_e next_state;
  logic pin_s1;
  logic pin_s2;
  logic protection_lock;
  logic array_protect;
  logic write_latch;
  logic program_fail_flag;
  logic soft_reset_allow;
  logic [7:0] wr_data;
  logic [3:0] rd_idx;
  logic [7:0] rd_shift;
  logic rd_started;
  logic [7:0] status_one;
  logic [7:0] status_two;

  // Protect pin passes two flops before use
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
    end else begin
      pin_s1 <= protect_n_pin;
      pin_s2 <= pin_s1;
    end
  end

  // ****************************************************************
  // Decoding
  // ****************************************************************
  wire pin_asserted = !pin_s2;
  wire protect_pin_state = pin_s2;
  wire op_in_progress = op_busy;
  wire commit = link.frame_end && (state == st_arg);
  wire full_bytes = link.aligned;
  wire has_data = full_bytes && (link.byte_cnt >= stat_pkg::BYTES_ONE_DATA);
  wire is_wen = (op_code == stat_pkg::OP_WRITE_ENABLE);
  wire is_wdis = (op_code == stat_pkg::OP_WRITE_DISABLE);
  wire is_wsr = (op_code == stat_pkg::OP_WRITE_STATUS);
  wire is_wsr2 = (op_code == stat_pkg::OP_WRITE_STATUS2);
  wire is_reset = (op_code == stat_pkg::OP_SOFT_RESET);
  wire is_otp = (op_code == stat_pkg::OP_OTP_PROGRAM);
  wire is_array = (op_code == stat_pkg::OP_PAGE_PROGRAM) ||
    (op_code == stat_pkg::OP_ERASE_PAGE) ||
    (op_code == stat_pkg::OP_ERASE_SMALL) ||
    (op_code == stat_pkg::OP_ERASE_LARGE) ||
    (op_code == stat_pkg::OP_CHIP_ERASE) ||
    (op_code == stat_pkg::OP_CHIP_ERASE_ALT);
  wire is_prog = is_array || is_otp;
  wire is_read = (link.byte_val == stat_pkg::OP_READ_STATUS);
  wire opcode_in = (state == st_cmd) && link.byte_done;

  // Status write applies only with latch set and a whole data byte
  wire wsr_ok = commit && is_wsr && write_latch && has_data;
  // Lock set with pin asserted ignores the whole write
  wire wsr_frozen = protection_lock && pin_asserted;
  wire wsr_apply = wsr_ok && !wsr_frozen;
  wire wsr2_apply = commit && is_wsr2 && write_latch && has_data;
  wire wen_done = commit && is_wen && full_bytes;
  wire wdis_done = commit && is_wdis && full_bytes;
  wire reset_done = commit && is_reset && full_bytes && soft_reset_allow;
  // Array work is blocked by the protect bit, OTP work is not
  wire start_ok = commit && is_prog && full_bytes && write_latch &&
    !op_in_progress && (is_otp || !array_protect);
  // Commit needs the whole opcode, so partial opcodes never clear
  wire latch_clear = wdis_done || (commit && (is_wsr || is_wsr2)) ||
    (commit && is_prog) || op_end || op_aborted || hold_abort ||
    reset_done;

  // ****************************************************************
  // Live status bytes
  // ****************************************************************
  always_comb begin
    status_one = 8'h00;
    status_one[stat_pkg::LOCK_BIT] = protection_lock;
    status_one[stat_pkg::FAIL_BIT] = program_fail_flag;
    status_one[stat_pkg::PIN_BIT] = protect_pin_state;
    status_one[stat_pkg::PROT_BIT] = array_protect;
    status_one[stat_pkg::LATCH_BIT] = write_latch;
    status_one[stat_pkg::BUSY_BIT] = op_in_progress;
    status_two = 8'h00;
    status_two[stat_pkg::ALLOW_BIT] = soft_reset_allow;
    status_two[stat_pkg::BUSY_BIT] = op_in_progress;
  end

  wire [7:0] live_byte = rd_idx[3] ? status_two : status_one;

  // ****************************************************************
  // Frame state machine
  // ****************************************************************
  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (link.frame_on) begin
          next_state = st_cmd;
        end
      end
      st_cmd: begin
        if (link.byte_done) begin
          next_state = is_read ? st_read : st_arg;
        end
      end
      st_read: begin
        next_state = st_read;
      end
      st_arg: begin
        next_state = st_arg;
      end
      default: begin
        next_state = st_idle;
      end
    endcase
    if (!link.frame_on) begin
      next_state = st_idle;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      op_code <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      state <= next_state;
      if (opcode_in) begin
        op_code <= link.byte_val;
      end
      if (link.byte_done && link.byte_cnt == stat_pkg::BYTES_OPCODE) begin
        wr_data <= link.byte_val;
      end
    end
  end

  // ****************************************************************
  // Status read shifter
  // ****************************************************************
  // A new byte is taken from live values at each byte start
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_idx <= 4'h0;
      rd_shift <= 8'h00;
      rd_started <= 1'b0;
      miso_out <= 1'b0;
    end else if (state != st_read) begin
      rd_idx <= 4'h0;
      rd_started <= 1'b0;
    end else if (link.sck_fall) begin
      rd_idx <= rd_idx + 4'h1;
      rd_started <= 1'b1;
      if (rd_idx[2:0] == 3'h0) begin
        miso_out <= live_byte[7];
        rd_shift <= {live_byte[6:0], 1'b0};
      end else begin
        miso_out <= rd_shift[7];
        rd_shift <= {rd_shift[6:0], 1'b0};
      end
    end
  end

  assign miso_oe = (state == st_read) && link.frame_on && rd_started;

  // ****************************************************************
  // Status bits
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      protection_lock <= stat_pkg::LOCK_RST;
      array_protect <= stat_pkg::PROT_RST;
      soft_reset_allow <= stat_pkg::ALLOW_RST;
    end else begin
      if (wsr_apply) begin
        protection_lock <= wr_data[stat_pkg::LOCK_BIT];
        array_protect <= wr_data[stat_pkg::PROT_BIT];
      end
      if (wsr2_apply) begin
        soft_reset_allow <= wr_data[stat_pkg::ALLOW_BIT];
      end
    end
  end

  // Write enable wins over a clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      write_latch <= stat_pkg::LATCH_RST;
    end else if (wen_done) begin
      write_latch <= 1'b1;
    end else if (latch_clear) begin
      write_latch <= 1'b0;
    end
  end

  // Only a completed, non-aborted operation updates the flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      program_fail_flag <= stat_pkg::FAIL_RST;
    end else if (op_end && !op_aborted) begin
      program_fail_flag <= op_error;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      op_start <= 1'b0;
      soft_reset <= 1'b0;
    end else begin
      op_start <= start_ok;
      soft_reset <= reset_done;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_read_entry: assert property (
    @(posedge core_clk) disable iff (rst)
    opcode_in && is_read && link.frame_on |=> state == st_read)
    else $error("status read opcode did not start the read");

  a_out_off: assert property (
    @(posedge core_clk) disable iff (rst)
    !link.frame_on |-> !miso_oe)
    else $error("serial output driven outside a frame");

  a_byte_order: assert property (
    @(posedge core_clk) disable iff (rst)
    state == st_read && link.sck_fall && link.frame_on &&
    rd_idx == 4'h8 |=> miso_out == $past(status_two[7]) &&
    rd_shift == {$past(status_two[6:0]), 1'b0})
    else $error("byte two not loaded fresh after byte one");

  a_busy_both: assert property (
    @(posedge core_clk) disable iff (rst)
    op_busy |-> status_one[0] && status_two[0])
    else $error("busy not shown at bit zero of both bytes");

  a_pin_mirror: assert property (
    @(posedge core_clk) disable iff (rst)
    $fell(protect_n_pin) |-> ##2 !status_one[stat_pkg::PIN_BIT])
    else $error("pin state bit not low two cycles after assertion");

  a_protect_frozen: assert property (
    @(posedge core_clk) disable iff (rst)
    protection_lock && pin_asserted |=>
    array_protect == $past(array_protect))
    else $error("protect bit changed while locked");

  a_lock_hold: assert property (
    @(posedge core_clk) disable iff (rst)
    protection_lock && pin_asserted |=> protection_lock)
    else $error("lock cleared while pin asserted");

  a_lock_write: assert property (
    @(posedge core_clk) disable iff (rst)
    wsr_ok && !protection_lock |=>
    protection_lock == $past(wr_data[7]) &&
    array_protect == $past(wr_data[2]))
    else $error("unlocked status write not applied");

  a_fail_abort: assert property (
    @(posedge core_clk) disable iff (rst)
    op_end && op_aborted |=> $stable(program_fail_flag))
    else $error("aborted operation changed failure flag");

  a_fail_update: assert property (
    @(posedge core_clk) disable iff (rst)
    op_end && !op_aborted |=> program_fail_flag == $past(op_error))
    else $error("failure flag not updated at operation end");

  a_start_gate: assert property (
    @(posedge core_clk) disable iff (rst)
    op_start |-> $past(write_latch) &&
    ($past(is_otp) || !$past(array_protect)))
    else $error("operation started without latch or while protected");

  a_latch_clear: assert property (
    @(posedge core_clk) disable iff (rst)
    commit && (is_prog || is_wsr) |=> !write_latch)
    else $error("latch not cleared after write-class command");

  a_latch_keep: assert property (
    @(posedge core_clk) disable iff (rst)
    link.frame_end && state == st_cmd && !op_end && !op_aborted &&
    !hold_abort |=> $stable(write_latch))
    else $error("partial opcode changed the latch");

endmodule : flash_status

//--- dv/host_spi_model.sv
// Host side of the serial link: a mode 0 master paced by the core clock.
// Assumes the bench calls its tasks at falling core clock edges.
`timescale 1ns/10ps
module host_spi_model (
  // Pacing clock
  input wire logic core_clk,
  // Serial pins
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe
);
  logic oe_seen;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    oe_seen = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_clk

  task automatic open_frame();
    wait_clk(1);
    cs_n = 1'b0;
    wait_clk(4);
  endtask : open_frame

  // Released data line toggles so a stale level is never mistaken for data
  task automatic close_frame();
    cs_n = 1'b1;
    mosi = ~mosi;
    wait_clk(8);
  endtask : close_frame

  // Shifts n bits MSB first; reply sampled just before each falling edge
  task automatic shift(input logic [7:0] tx, input int n,
                       output logic [7:0] rx);
    rx = 8'h00;
    oe_seen = 1'b1;
    for (int i = 7; i > 7 - n; i--) begin
      mosi = tx[i];
      wait_clk(4);
      sck = 1'b1;
      wait_clk(4);
      // A released output reads inverted, so lost drive shows up
      rx[i] = miso_oe ? miso_out : ~miso_out;
      oe_seen = oe_seen & miso_oe;
      sck = 1'b0;
    end
  endtask : shift
endmodule : host_spi_model

//--- dv/testbench.sv
// Self-checking bench for the flash status register block.
// Assumes a host model on the serial pins and engine pulses from here.
`timescale 1ns/10ps
module testbench;
  logic core_clk, rst, sck, cs_n, mosi, miso_out, miso_oe;
  logic protect_n, op_busy, op_end, op_error, op_aborted, hold_abort;
  logic op_start, soft_reset;
  logic [7:0] op_code, b1, b2, rx;
  int err_count, checked, starts, resets;

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  flash_status dut (.core_clk(core_clk), .rst(rst), .sck_pin(sck),
    .cs_n_pin(cs_n), .mosi_pin(mosi), .miso_out(miso_out),
    .miso_oe(miso_oe), .protect_n_pin(protect_n), .op_busy(op_busy),
    .op_end(op_end), .op_error(op_error), .op_aborted(op_aborted),
    .hold_abort(hold_abort), .op_start(op_start), .op_code(op_code),
    .soft_reset(soft_reset));

  host_spi_model host (.core_clk(core_clk), .sck(sck), .cs_n(cs_n),
    .mosi(mosi), .miso_out(miso_out), .miso_oe(miso_oe));

  always @(negedge core_clk) begin
    if (op_start === 1'b1) starts++;
    if (soft_reset === 1'b1) resets++;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (err_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic cmd(input logic [7:0] op, input logic [7:0] d,
                     input int nd);
    host.open_frame();
    host.shift(op, 8, rx);
    if (nd > 0) host.shift(d, 8, rx);
    host.close_frame();
  endtask : cmd

  task automatic rd();
    host.open_frame();
    host.shift(8'h05, 8, rx);
    host.shift(8'h00, 8, b1);
    host.shift(8'h00, 8, b2);
    host.close_frame();
  endtask : rd

  task automatic engine(input logic err, input logic abt);
    op_error = err;
    op_aborted = abt;
    op_end = 1'b1;
    host.wait_clk(1);
    op_end = 1'b0;
    op_aborted = 1'b0;
    host.wait_clk(2);
  endtask : engine

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    host.open_frame();
    host.shift(8'h05, 8, rx);
    for (int r = 0; r < 2; r++) begin
      host.shift(8'h00, 8, b1);
      host.shift(8'h00, 8, b2);
      check(b1, 8'h10);
      check(b2, 8'h00);
    end
    check({7'h00, host.oe_seen}, 8'h01);
    host.close_frame();
    check({7'h00, miso_oe}, 8'h00);
  endtask : t_reset

  task automatic t_live();
    op_busy = 1'b1;
    rd();
    check(b1, 8'h11);
    check(b2, 8'h01);
    op_busy = 1'b0;
    host.open_frame();
    host.shift(8'h05, 8, rx);
    host.shift(8'h00, 8, b1);
    op_busy = 1'b1;
    protect_n = 1'b0;
    host.shift(8'h00, 8, b2);
    check(b2, 8'h01);
    host.shift(8'h00, 8, b1);
    check(b1, 8'h01);
    op_busy = 1'b0;
    protect_n = 1'b1;
    host.shift(8'h00, 8, b2);
    check(b2, 8'h00);
    host.close_frame();
  endtask : t_live

  task automatic t_write();
    cmd(8'h06, 8'h00, 0);
    rd();
    check(b1, 8'h12);
    cmd(8'h01, 8'hff, 1);
    rd();
    check(b1, 8'h94);
    cmd(8'h01, 8'h00, 1);
    rd();
    check(b1, 8'h94);
    cmd(8'h06, 8'h00, 0);
    host.open_frame();
    host.shift(8'h01, 8, rx);
    host.shift(8'h00, 4, rx);
    host.close_frame();
    rd();
    check(b1, 8'h94);
  endtask : t_write

  task automatic t_lock();
    protect_n = 1'b0;
    cmd(8'h06, 8'h00, 0);
    cmd(8'h01, 8'h00, 1);
    rd();
    check(b1, 8'h84);
    protect_n = 1'b1;
    cmd(8'h06, 8'h00, 0);
    cmd(8'h01, 8'h00, 1);
    rd();
    check(b1, 8'h10);
    protect_n = 1'b0;
    cmd(8'h06, 8'h00, 0);
    cmd(8'h01, 8'h80, 1);
    rd();
    check(b1, 8'h80);
    protect_n = 1'b1;
    cmd(8'h06, 8'h00, 0);
    cmd(8'h01, 8'h00, 1);
  endtask : t_lock

  task automatic t_latch();
    int s0;
    cmd(8'h06, 8'h00, 0);
    host.open_frame();
    host.shift(8'h00, 4, rx);
    host.close_frame();
    rd();
    check(b1, 8'h12);
    cmd(8'h04, 8'h00, 0);
    rd();
    check(b1, 8'h10);
    s0 = starts;
    cmd(8'h02, 8'h00, 0);
    check(8'(starts - s0), 8'h00);
    cmd(8'h06, 8'h00, 0);
    cmd(8'h02, 8'h00, 0);
    check(op_code, 8'h02);
    rd();
    check(b1, 8'h10);
    check(8'(starts - s0), 8'h01);
    cmd(8'h06, 8'h00, 0);
    cmd(8'h01, 8'h04, 1);
    cmd(8'h06, 8'h00, 0);
    cmd(8'h02, 8'h00, 0);
    check(8'(starts - s0), 8'h01);
    cmd(8'h06, 8'h00, 0);
    cmd(8'h9b, 8'h00, 0);
    check(8'(starts - s0), 8'h02);
    cmd(8'h06, 8'h00, 0);
    hold_abort = 1'b1;
    host.wait_clk(1);
    hold_abort = 1'b0;
    rd();
    check(b1, 8'h14);
    cmd(8'h06, 8'h00, 0);
    cmd(8'h01, 8'h00, 1);
  endtask : t_latch

  task automatic t_fail();
    engine(1'b1, 1'b0);
    rd();
    check(b1, 8'h30);
    engine(1'b0, 1'b0);
    rd();
    check(b1, 8'h10);
    engine(1'b1, 1'b1);
    rd();
    check(b1, 8'h10);
  endtask : t_fail

  task automatic t_soft();
    int r0;
    r0 = resets;
    cmd(8'hf0, 8'h00, 0);
    check(8'(resets - r0), 8'h00);
    cmd(8'h06, 8'h00, 0);
    cmd(8'h31, 8'h10, 1);
    rd();
    check(b2, 8'h10);
    cmd(8'h06, 8'h00, 0);
    cmd(8'hf0, 8'h00, 0);
    rd();
    check(8'(resets - r0), 8'h01);
    check(b1, 8'h10);
  endtask : t_soft

  task automatic t_abort();
    host.open_frame();
    host.shift(8'h05, 8, rx);
    host.shift(8'h00, 5, b1);
    check(b1, 8'h10);
    host.close_frame();
    check({7'h00, miso_oe}, 8'h00);
    rd();
    check(b1, 8'h10);
    check(b2, 8'h10);
  endtask : t_abort

  // Reset in mid-run with lock, protect, latch and allow all set
  task automatic t_rerst();
    cmd(8'h06, 8'h00, 0);
    cmd(8'h01, 8'h84, 1);
    cmd(8'h06, 8'h00, 0);
    rst = 1'b1;
    host.wait_clk(2);
    rst = 1'b0;
    host.wait_clk(3);
    rd();
    check(b1, 8'h10);
    check(b2, 8'h00);
  endtask : t_rerst

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    rst = 1'b1;
    protect_n = 1'b1;
    op_busy = 1'b0;
    op_end = 1'b0;
    op_error = 1'b0;
    op_aborted = 1'b0;
    hold_abort = 1'b0;
    err_count = 0;
    checked = 0;
    starts = 0;
    resets = 0;
    host.wait_clk(2);
    rst = 1'b0;
    host.wait_clk(3);
    t_reset();
    t_live();
    t_write();
    t_lock();
    t_latch();
    t_fail();
    t_soft();
    t_abort();
    t_rerst();
    print_verdict();
  end

  // About 8100 cycles of tests; the 20000-cycle limit is about 2.5 times that
  initial begin
    #400000;
    err_count++;
    print_verdict();
  end
endmodule : testbench
